// [rtl/vsbc_pkg.sv]
// Purpose: shared constants and types for the video RAM strobe and bank configuration block
// Assumes: 25 MHz system clock, four row and four column strobes, 11-bit memory address
// Notes:   strobe vectors on the pins are active low; selection masks inside are active high
package vsbc_pkg;

  // ==========================================================================
  // widths and clock
  // ==========================================================================
  localparam int ADDR_W = 11;            // memory address outputs
  localparam int NSTROBE = 4;            // row and column strobes each
  localparam int CNT_W = 3;              // phase counter width
  localparam int CLK_PERIOD_NS = 40;     // 25 MHz

  // ==========================================================================
  // timing figures as specified, in ns
  // ==========================================================================
  localparam int ROW_HOLD_LONG_NS = 25;  // row hold select = 0
  localparam int ROW_HOLD_SHORT_NS = 15; // row hold select = 1
  localparam int COL_SETUP_LONG_NS = 10; // column setup select = 0
  localparam int COL_SETUP_SHORT_NS = 0; // column setup select = 1
  localparam int REFRESH_LOW_NS = 120;   // row strobe low time during refresh
  localparam int PRECHARGE_NS = 80;      // strobe high time after any cycle

  // least time rounded up to whole cycles, never below one cycle
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : min_cycles

  localparam logic [CNT_W-1:0] ROW_HOLD_LONG_CYC = CNT_W'(min_cycles(ROW_HOLD_LONG_NS));
  localparam logic [CNT_W-1:0] ROW_HOLD_SHORT_CYC = CNT_W'(min_cycles(ROW_HOLD_SHORT_NS));
  localparam logic [CNT_W-1:0] COL_SETUP_LONG_CYC = CNT_W'(min_cycles(COL_SETUP_LONG_NS));
  localparam logic [CNT_W-1:0] COL_SETUP_SHORT_CYC = CNT_W'(min_cycles(COL_SETUP_SHORT_NS));
  localparam logic [CNT_W-1:0] REFRESH_CYC = CNT_W'(min_cycles(REFRESH_LOW_NS));
  localparam logic [CNT_W-1:0] PRECHARGE_CYC = CNT_W'(min_cycles(PRECHARGE_NS));
  localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;

  // ==========================================================================
  // configuration codes and masks
  // ==========================================================================
  typedef logic [2:0] vsbc_code_t;
  localparam vsbc_code_t CFG_ALL_SCRUB = 3'h0;     // all strobes, scrub on refresh
  localparam vsbc_code_t CFG_PAIR_SCRUB = 3'h1;    // pairs by high bank select
  localparam vsbc_code_t CFG_SINGLE_SCRUB = 3'h2;  // singles by both bank selects
  localparam vsbc_code_t CFG_ALL_NOSCRUB = 3'h3;   // all strobes, row-only refresh

  localparam logic [NSTROBE-1:0] MASK_ALL = 4'hf;
  localparam logic [NSTROBE-1:0] MASK_LOW_PAIR = 4'h3;
  localparam logic [NSTROBE-1:0] MASK_HIGH_PAIR = 4'hc;
  localparam logic [NSTROBE-1:0] MASK_ONE = 4'h1;
  localparam logic [NSTROBE-1:0] MASK_NONE = 4'h0;
  localparam logic [NSTROBE-1:0] STROBE_OFF = 4'hf; // active-low idle level
  localparam logic [NSTROBE-1:0] STROBE_ALL_ON = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 11'h000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 11'h001;

  // memory cycle sequencer states
  typedef enum logic [2:0] {
    S_IDLE, S_ROW_HOLD, S_COL_SETUP, S_COL, S_REFRESH, S_PRECHARGE
  } vsbc_state_t;

endpackage : vsbc_pkg

// [rtl/vsbc_sel_if.sv]
// Purpose: carries configuration code, bank selects and decoded strobe selections
// Assumes: one decoder and one sequencer on the same clock
// Notes:   purely combinational signals, no clocking
`timescale 1ns/100ps
`default_nettype none
interface vsbc_sel_if;
  import vsbc_pkg::*;
  vsbc_code_t code;             // configuration code
  logic bank_high;              // upper bank select
  logic bank_low;               // lower bank select
  logic [NSTROBE-1:0] row_sel;  // selected row strobes, active high
  logic [NSTROBE-1:0] col_sel;  // selected column strobes, active high
  logic scrub;                  // refreshes perform scrubbing

  modport decoder (input code, input bank_high, input bank_low,
                   output row_sel, output col_sel, output scrub);
  modport user (output code, output bank_high, output bank_low,
                input row_sel, input col_sel, input scrub);
endinterface : vsbc_sel_if
`default_nettype wire

// [rtl/vsbc_bank_decode.sv]
// Purpose: maps configuration code and bank selects onto strobe selections
// Assumes: codes above 011 are not driven; the controller adds no handling of its own for them
// Notes:   combinational; the sequencer registers everything it drives out
`timescale 1ns/100ps
`default_nettype none
module vsbc_bank_decode (
  vsbc_sel_if.decoder sel // code in, selections out
);
  import vsbc_pkg::*;

  // ==========================================================================
  // decode
  // ==========================================================================
  // one mask feeds both row and column selection so they can never disagree
  always_comb begin
    sel.row_sel = MASK_NONE;
    sel.col_sel = MASK_NONE;
    sel.scrub = 1'b0;
    unique case (sel.code)
      CFG_ALL_SCRUB: begin // bank selects ignored
        sel.row_sel = MASK_ALL;
        sel.scrub = 1'b1;
      end
      CFG_PAIR_SCRUB: begin // low bank select ignored
        sel.row_sel = sel.bank_high ? MASK_HIGH_PAIR : MASK_LOW_PAIR;
        sel.scrub = 1'b1;
      end
      CFG_SINGLE_SCRUB: begin // exactly one strobe
        sel.row_sel = MASK_ONE << {sel.bank_high, sel.bank_low};
        sel.scrub = 1'b1;
      end
      CFG_ALL_NOSCRUB: begin // row-only refresh
        sel.row_sel = MASK_ALL;
        sel.scrub = 1'b0;
      end
      default: begin // codes outside this block select nothing
        sel.row_sel = MASK_NONE;
        sel.scrub = 1'b0;
      end
    endcase
    sel.col_sel = sel.row_sel; // column selection follows row selection
  end

endmodule : vsbc_bank_decode
`default_nettype wire

// [rtl/vsbc_strobe_ctl.sv]
// Purpose: memory cycle sequencer driving row/column strobes and the address mux
// Assumes: request and configuration inputs are synchronous to clk
// Notes:   refresh wins over an access requested in the same cycle
//
// Functional notes
// - row address held per row hold select
// - column address set up per setup select
// - column strobe in an access needs its extend input asserted
// - code 000: all strobes, scrub refreshes
// - code 001: pairs by upper bank select
// - code 010: one strobe from both selects
// - code 011: all strobes, row-only refresh
`timescale 1ns/100ps
`default_nettype none
module vsbc_strobe_ctl (
  input wire logic clk,                                           // 25 MHz system clock
  input wire logic rst,                                           // async reset, active high
  input wire logic row_hold_select,                               // 0: long row hold, 1: short
  input wire logic col_setup_select,                              // 0: long col setup, 1: short
  input wire vsbc_pkg::vsbc_code_t strobe_config_code,            // strobe configuration code
  input wire logic bank_select_low,                               // lower bank select
  input wire logic bank_select_high,                              // upper bank select
  input wire logic access_req,                                    // access request, held for access
  input wire logic refresh_req,                                   // refresh request level
  input wire logic [vsbc_pkg::ADDR_W-1:0] row_addr_in,            // row address
  input wire logic [vsbc_pkg::ADDR_W-1:0] col_addr_in,            // column address
  input wire logic [vsbc_pkg::NSTROBE-1:0] extend_column_strobe_in, // per-strobe enables
  output logic [vsbc_pkg::ADDR_W-1:0] mem_addr,                   // multiplexed memory address
  output logic [vsbc_pkg::NSTROBE-1:0] row_strobe_n,              // row strobes, active low
  output logic [vsbc_pkg::NSTROBE-1:0] col_strobe_n,              // column strobes, active low
  output logic scrub_cycle,                                       // scrubbing refresh running
  output logic busy                                               // cycle in progress
);
  import vsbc_pkg::*;

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    vsbc_state_t fsm;               // sequencer state
    logic [CNT_W-1:0] cnt;          // cycles left in phase
    vsbc_code_t code;               // code latched at access start
    logic bank_high;                // bank selects latched at access start
    logic bank_low;
    logic [NSTROBE-1:0] col_sel;    // column selection for this access
    logic scrub;                    // current refresh scrubs
    logic [ADDR_W-1:0] ref_row;     // next row to refresh
    logic [ADDR_W-1:0] mem_addr;    // address outputs
    logic [NSTROBE-1:0] row_n;      // row strobe outputs
    logic [NSTROBE-1:0] col_n;      // column strobe outputs
    logic busy;                     // busy output
  } vsbc_regs_t;

  vsbc_regs_t st;      // registered state
  vsbc_regs_t next_st; // next state
  vsbc_sel_if sel ();  // decoder link

  // decoder sees the live inputs; selection is captured when an access starts
  assign sel.code = strobe_config_code;
  assign sel.bank_high = bank_select_high;
  assign sel.bank_low = bank_select_low;

  vsbc_bank_decode u_decode (
    .sel (sel.decoder)
  );

  // ==========================================================================
  // sequencer
  // ==========================================================================
  // row hold and column setup lengths come from the select bits at the moment each phase starts
  always_comb begin
    next_st = st;
    unique case (st.fsm)
      S_IDLE: begin
        if (refresh_req) begin // refresh has priority over access
          next_st.fsm = S_REFRESH;
          next_st.cnt = REFRESH_CYC - CNT_ONE;
          next_st.mem_addr = st.ref_row;
          next_st.row_n = STROBE_OFF & ~MASK_ALL; // refresh takes every row strobe
          next_st.scrub = sel.scrub;
          // scrubbing reads the row back, so columns go low regardless of extends
          next_st.col_n = sel.scrub ? STROBE_ALL_ON : STROBE_OFF;
          next_st.busy = 1'b1;
        end else if (access_req) begin
          next_st.fsm = S_ROW_HOLD;
          next_st.cnt = (row_hold_select ? ROW_HOLD_SHORT_CYC : ROW_HOLD_LONG_CYC) - CNT_ONE;
          next_st.code = strobe_config_code;
          next_st.bank_high = bank_select_high;
          next_st.bank_low = bank_select_low;
          next_st.col_sel = sel.col_sel;
          next_st.mem_addr = row_addr_in;
          next_st.row_n = ~sel.row_sel;
          next_st.busy = 1'b1;
        end
      end
      S_ROW_HOLD: begin
        // row address stays on the pins until the hold count runs out
        if (st.cnt == CNT_ZERO) begin
          next_st.fsm = S_COL_SETUP;
          next_st.cnt = (col_setup_select ? COL_SETUP_SHORT_CYC : COL_SETUP_LONG_CYC) - CNT_ONE;
          next_st.mem_addr = col_addr_in;
        end else begin
          next_st.cnt = st.cnt - CNT_ONE;
        end
      end
      S_COL_SETUP: begin
        // column strobes wait for the setup count on a stable column address
        if (st.cnt == CNT_ZERO) begin
          next_st.fsm = S_COL;
          next_st.col_n = ~(st.col_sel & extend_column_strobe_in);
        end else begin
          next_st.cnt = st.cnt - CNT_ONE;
        end
      end
      S_COL: begin
        if (!access_req) begin // access over: all strobes negate together
          next_st.fsm = S_PRECHARGE;
          next_st.cnt = PRECHARGE_CYC - CNT_ONE;
          next_st.row_n = STROBE_OFF;
          next_st.col_n = STROBE_OFF;
        end else begin
          // extends are followed every cycle, so a strobe can drop and come back
          next_st.col_n = ~(st.col_sel & extend_column_strobe_in);
        end
      end
      S_REFRESH: begin
        if (st.cnt == CNT_ZERO) begin
          next_st.fsm = S_PRECHARGE;
          next_st.cnt = PRECHARGE_CYC - CNT_ONE;
          next_st.row_n = STROBE_OFF;
          next_st.col_n = STROBE_OFF;
          next_st.scrub = 1'b0;
          next_st.ref_row = st.ref_row + ADDR_ONE;
        end else begin
          next_st.cnt = st.cnt - CNT_ONE;
        end
      end
      S_PRECHARGE: begin
        // precharge is enforced here rather than trusted to the requester
        if (st.cnt == CNT_ZERO) begin
          next_st.fsm = S_IDLE;
          next_st.busy = 1'b0;
        end else begin
          next_st.cnt = st.cnt - CNT_ONE;
        end
      end
    endcase
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st.fsm <= S_IDLE;
      st.cnt <= CNT_ZERO;
      st.code <= CFG_ALL_SCRUB;
      st.bank_high <= 1'b0;
      st.bank_low <= 1'b0;
      st.col_sel <= MASK_NONE;
      st.scrub <= 1'b0;
      st.ref_row <= ADDR_ZERO;
      st.mem_addr <= ADDR_ZERO;
      st.row_n <= STROBE_OFF;
      st.col_n <= STROBE_OFF;
      st.busy <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // outputs are straight register bits
  assign mem_addr = st.mem_addr;
  assign row_strobe_n = st.row_n;
  assign col_strobe_n = st.col_n;
  assign scrub_cycle = st.scrub;
  assign busy = st.busy;

  // ==========================================================================
  // checks
  // ==========================================================================
  logic in_access; // helper: access phases with row strobes low
  assign in_access = (st.fsm == S_ROW_HOLD) || (st.fsm == S_COL_SETUP) || (st.fsm == S_COL);

  chk_row_hold_addr: assert property (@(posedge clk) disable iff (rst)
    (st.fsm == S_ROW_HOLD && $past(st.fsm) == S_IDLE)
      |-> (mem_addr == $past(row_addr_in)) ##1 (row_strobe_n == $past(row_strobe_n)))
    else $error("row address not held while row strobe low");

  chk_col_setup_addr: assert property (@(posedge clk) disable iff (rst)
    (st.fsm == S_COL && $past(st.fsm) == S_COL_SETUP) |-> $stable(mem_addr) && $past(col_strobe_n) == STROBE_OFF)
    else $error("column strobe without column address setup");

  chk_col_extend_gate: assert property (@(posedge clk) disable iff (rst)
    (st.fsm == S_COL) |-> ((~col_strobe_n) & ~$past(extend_column_strobe_in)) == MASK_NONE)
    else $error("column strobe asserted without its extend input");

  chk_all_scrub_cfg: assert property (@(posedge clk) disable iff (rst)
    (in_access && st.code == CFG_ALL_SCRUB) |-> row_strobe_n == STROBE_ALL_ON)
    else $error("code 000 did not select every row strobe");

  chk_pair_cfg: assert property (@(posedge clk) disable iff (rst)
    (in_access && st.code == CFG_PAIR_SCRUB)
      |-> row_strobe_n == ~(st.bank_high ? MASK_HIGH_PAIR : MASK_LOW_PAIR))
    else $error("code 001 pair selection wrong");

  chk_single_cfg: assert property (@(posedge clk) disable iff (rst)
    (in_access && st.code == CFG_SINGLE_SCRUB)
      |-> row_strobe_n == ~(MASK_ONE << {st.bank_high, st.bank_low}) && st.col_sel == ~row_strobe_n)
    else $error("code 010 single selection wrong");

  chk_row_only_refresh: assert property (@(posedge clk) disable iff (rst)
    (st.fsm == S_IDLE && refresh_req && strobe_config_code == CFG_ALL_NOSCRUB)
      |=> (col_strobe_n == STROBE_OFF && !scrub_cycle)[*3])
    else $error("code 011 refresh drove column strobes");

  chk_scrub_refresh: assert property (@(posedge clk) disable iff (rst)
    (st.fsm == S_IDLE && refresh_req && strobe_config_code == CFG_ALL_SCRUB)
      |=> (col_strobe_n == STROBE_ALL_ON && scrub_cycle && row_strobe_n == STROBE_ALL_ON))
    else $error("code 000 refresh did not scrub");

endmodule : vsbc_strobe_ctl
`default_nettype wire

// [tb/vsbc_mem_model.sv]
// Purpose: memory array stand-in that latches row, column and strobes per cycle
// Assumes: strobes and address settle well before the falling clock edge
// Notes:   one record is reported two cycles after any row strobe falls
`timescale 1ns/100ps
`default_nettype none
module vsbc_mem_model (
  input wire logic clk,                                      // system clock
  input wire logic rst,                                      // async reset
  input wire logic [vsbc_pkg::ADDR_W-1:0] mem_addr,          // address pins
  input wire logic [vsbc_pkg::NSTROBE-1:0] row_strobe_n,     // row strobes
  input wire logic [vsbc_pkg::NSTROBE-1:0] col_strobe_n,     // column strobes
  input wire logic scrub_cycle,                              // scrub flag
  output logic done,                                         // record ready
  output logic [41:0] rec                                    // rs, a0, a1, a2, cs, scrub
);
  import vsbc_pkg::*;
  logic [NSTROBE-1:0] prev_rs; // row strobes one cycle back
  logic [1:0] phase;           // 0 waits for a row strobe fall

  // ==========================================================================
  // sampling
  // ==========================================================================
  // falling edge sampling keeps the array clear of the edge the block drives on
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      prev_rs <= STROBE_OFF;
      phase <= 2'h0;
      done <= 1'b0;
      rec <= '0;
    end else begin
      prev_rs <= row_strobe_n;
      done <= 1'b0;
      if (phase == 2'h0 && prev_rs == STROBE_OFF && row_strobe_n != STROBE_OFF) begin
        rec[41:27] <= {row_strobe_n, mem_addr}; // row latched as its strobe falls
        rec[0] <= scrub_cycle;
        phase <= 2'h1;
      end else if (phase == 2'h1) begin
        rec[26:16] <= mem_addr; // column must stand a cycle ahead of its strobe
        phase <= 2'h2;
      end else if (phase == 2'h2) begin
        rec[15:1] <= {mem_addr, col_strobe_n}; // column latched with its strobes
        done <= 1'b1;
        phase <= 2'h0;
      end
    end
  end
endmodule : vsbc_mem_model
`default_nettype wire

// [tb/test_vsbc_strobe_ctl.sv]
// Purpose: self-checking bench for the strobe sequencer and bank decode
// Assumes: design answers per its hand-over timing, codes 000 to 011 only
// Notes:   driver queues expected records, a monitor compares model records
`timescale 1ns/100ps
`default_nettype none
module test_vsbc_strobe_ctl;
  import vsbc_pkg::*;
  typedef struct packed {
    logic [3:0] rs;
    logic [10:0] a0;
    logic [10:0] a1;
    logic [10:0] a2;
    logic [3:0] cs;
    logic scrub;
  } vsbc_note_t;
  logic clk = 1'b0; // system clock
  logic rst = 1'b1; // held from time zero
  logic row_hold_select = 1'b0;
  logic col_setup_select = 1'b0;
  vsbc_code_t strobe_config_code = CFG_ALL_SCRUB;
  logic bank_select_low = 1'b0;
  logic bank_select_high = 1'b0;
  logic access_req = 1'b0;
  logic refresh_req = 1'b0;
  logic [ADDR_W-1:0] row_addr_in = ADDR_ZERO;
  logic [ADDR_W-1:0] col_addr_in = ADDR_ZERO;
  logic [NSTROBE-1:0] extend_column_strobe_in = MASK_NONE;
  logic [ADDR_W-1:0] mem_addr;
  logic [NSTROBE-1:0] row_strobe_n;
  logic [NSTROBE-1:0] col_strobe_n;
  logic scrub_cycle;
  logic busy;
  logic done;
  logic [41:0] rec;
  vsbc_note_t notes[$]; // expected records, oldest first
  vsbc_note_t exp_n;
  vsbc_note_t got_n;
  logic [31:0] seed = 32'h303a; // fixed seed
  logic [ADDR_W-1:0] ref_row = ADDR_ZERO; // expected refresh row
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  // ==========================================================================
  // clock, design and memory model
  // ==========================================================================
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  vsbc_strobe_ctl dut (.clk(clk), .rst(rst), .row_hold_select(row_hold_select),
    .col_setup_select(col_setup_select), .strobe_config_code(strobe_config_code),
    .bank_select_low(bank_select_low), .bank_select_high(bank_select_high), .access_req(access_req),
    .refresh_req(refresh_req), .row_addr_in(row_addr_in), .col_addr_in(col_addr_in),
    .extend_column_strobe_in(extend_column_strobe_in), .mem_addr(mem_addr),
    .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .scrub_cycle(scrub_cycle), .busy(busy));
  vsbc_mem_model mdl (.clk(clk), .rst(rst), .mem_addr(mem_addr), .row_strobe_n(row_strobe_n),
    .col_strobe_n(col_strobe_n), .scrub_cycle(scrub_cycle), .done(done), .rec(rec));

  // ==========================================================================
  // helpers
  // ==========================================================================
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // expected selection mask, worked out from the code table
  function automatic logic [3:0] sel_of(input vsbc_code_t c, input logic h, input logic l);
    case (c)
      CFG_ALL_SCRUB, CFG_ALL_NOSCRUB: return MASK_ALL; // bank selects ignored
      CFG_PAIR_SCRUB: return h ? MASK_HIGH_PAIR : MASK_LOW_PAIR;
      CFG_SINGLE_SCRUB: return MASK_ONE << {h, l};
      default: return MASK_NONE;
    endcase
  endfunction : sel_of

  task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic results;
    if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  // bounded wait for the cycle to finish, plus one spare cycle
  task automatic idle_wait;
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 20) begin
      @(negedge clk);
      k++;
    end
    check("busy_end", ADDR_ZERO, {10'h0, busy});
    @(negedge clk);
  endtask : idle_wait

  // one access with random addresses, extends and timing selects
  task automatic do_access(input vsbc_code_t c, input logic [1:0] b);
    vsbc_note_t n;
    logic [3:0] s;
    int k;
    seed = xs(seed);
    strobe_config_code = c;
    {bank_select_high, bank_select_low} = b;
    {row_addr_in, col_addr_in, extend_column_strobe_in} = seed[25:0];
    {row_hold_select, col_setup_select} = seed[31:30];
    access_req = 1'b1;
    s = sel_of(c, b[1], b[0]);
    n = '{~s, row_addr_in, col_addr_in, col_addr_in, ~(s & extend_column_strobe_in), 1'b0};
    notes.push_back(n);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (row_strobe_n === STROBE_OFF && k < 10);
    repeat (2) @(negedge clk);
    // fresh extends for one more column cycle, so the strobes must follow them live
    extend_column_strobe_in = seed[29:26];
    @(negedge clk);
    access_req = 1'b0; // ends the access after the column strobe
    idle_wait();
  endtask : do_access

  // cnt refreshes back to back, request held across them
  task automatic do_refresh(input vsbc_code_t c, input int cnt);
    vsbc_note_t n;
    strobe_config_code = c;
    refresh_req = 1'b1;
    repeat (cnt) begin
      n = '{STROBE_ALL_ON, ref_row, ref_row, ref_row,
            (c == CFG_ALL_NOSCRUB) ? STROBE_OFF : STROBE_ALL_ON, c != CFG_ALL_NOSCRUB};
      notes.push_back(n);
      ref_row++;
    end
    // precharge plus the idle edge put the next refresh six edges after the last
    repeat (6 * cnt - 5) @(negedge clk);
    refresh_req = 1'b0;
    idle_wait();
  endtask : do_refresh

  // ==========================================================================
  // monitor: each model record is matched against the oldest note
  // ==========================================================================
  always @(posedge clk) begin
    if (done === 1'b1) begin
      if (notes.size() == 0) begin
        check("unexpected_cycle", ADDR_ZERO, ADDR_ONE);
      end else begin
        exp_n = notes.pop_front();
        got_n = rec;
        check("row_strobe", 11'(exp_n.rs), 11'(got_n.rs));
        check("row_addr", exp_n.a0, got_n.a0);
        check("col_addr_setup", exp_n.a1, got_n.a1);
        check("col_addr", exp_n.a2, got_n.a2);
        check("col_strobe", 11'(exp_n.cs), 11'(got_n.cs));
        check("scrub", 11'(exp_n.scrub), 11'(got_n.scrub));
      end
    end
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      results();
    end
  end

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    // every code with every bank select pair, then a refresh in that code
    for (int c = 0; c < 4; c++) begin
      for (int b = 0; b < 4; b++) begin
        do_access(vsbc_code_t'(c), 2'(b));
      end
      do_refresh(vsbc_code_t'(c), 1);
    end
    repeat (20) begin
      seed = xs(seed);
      do_access(vsbc_code_t'({1'b0, seed[1:0]}), seed[3:2]);
    end
    do_refresh(CFG_SINGLE_SCRUB, 2);
    do_refresh(CFG_ALL_NOSCRUB, 2);
    repeat (4) @(negedge clk);
    check("notes_left", ADDR_ZERO, 11'(notes.size()));
    results();
  end
endmodule : test_vsbc_strobe_ctl
`default_nettype wire
